// ---- core/tpc_top.sv ----
`timescale 1ns/100ps
module tpc_top
	import tpc_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [7:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic                  fixed_tick_i,
	input  wire logic [2:0]            ext_tick_i,
	input  wire logic                  cmp_zero_i,
	input  wire logic                  cmp_one_i,
	input  wire logic                  port_a_pin6_i,
	input  wire logic                  port_a_pin7_i,
	input  wire logic                  rtc_ovf_i,
	input  wire logic                  serial0_receive_i,
	input  wire logic                  serial0_tx_raw_i,
	output logic                       serial0_transmit_o,
	input  wire logic [1:0]            t0_cap_pin_i,
	input  wire logic [1:0]            t1_cap_pin_i,
	input  wire logic [FULL_CH-1:0]    t2_cap_pin_i,
	output logic      [1:0]            t0_pwm_o,
	output logic      [1:0]            t1_pwm_o,
	output logic      [FULL_CH-1:0]    t2_pwm_o,
	output logic      [2:0]            irq_o
);
	logic [31:0] opt;
	logic [11:0] ctrl [3];
	logic [CNT_W-1:0] modv [3];
	logic [CNT_W-1:0] cnt [3];
	logic [9:0]  stat [3];
	logic [2:0]  ovf;
	logic [17:0] chr [10];
	logic [FAULT_N-1:0] fault_raw;
	logic [FAULT_N-1:0] fault_f;
	logic [FAULT_N-1:0] fault_en;
	logic [FILT_CH-1:0] t2_cap_f;
	logic sw_sync;
	logic t0_ch0_d;
	logic [2:0] sync_trig;
	logic fault_any;
	logic wr;
	logic rd_ok;
	logic [31:0] rd;
	logic [1:0]  t;
	logic [7:0]  o;
	logic        tsel;
	logic [3:0]  ci;

	tpc_ch_if #(.N(BASIC_CH)) c0 ();
	tpc_ch_if #(.N(BASIC_CH)) c1 ();
	tpc_ch_if #(.N(FULL_CH))  c2 ();

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i == 4'hF;

	always_comb
	begin
		tsel = 1'b1;
		t = 2'd0;
		o = 8'h00;
		if (adr_i >= ADR_T0_BASE && adr_i < ADR_T1_BASE)
		begin
			t = 2'd0;
			o = adr_i - ADR_T0_BASE;
		end
		else if (adr_i >= ADR_T1_BASE && adr_i < ADR_T2_BASE)
		begin
			t = 2'd1;
			o = adr_i - ADR_T1_BASE;
		end
		else if (adr_i >= ADR_T2_BASE && adr_i < ADR_T2_CH45)
		begin
			t = 2'd2;
			o = adr_i - ADR_T2_BASE;
		end
		else
			tsel = 1'b0;
	end

	// Channel register index: timer 0 ch 0..1, timer 1 ch 2..3, timer 2 ch 4..9
	always_comb
	begin
		ci = 4'hF;
		if (adr_i == ADR_T2_CH45)
			ci = 4'd8;
		else if (adr_i == ADR_T2_CH45 + 8'h04)
			ci = 4'd9;
		else if (tsel && o >= OFS_C0 && o <= OFS_C3)
		begin
			if (t == 2'd2)
				ci = 4'(4 + ((o - OFS_C0) >> 2));
			else if (o <= OFS_C1)
				ci = 4'({t, 1'b0} + ((o - OFS_C0) >> 2));
		end
	end

	always_comb
	begin
		rd = 32'h0;
		rd_ok = 1'b1;
		if (adr_i == ADR_OPTION)
			rd = {opt[31:2], 1'b0, opt[0]};
		else if (ci != 4'hF)
			rd = {14'h0, chr[ci][17:16],
				chr[ci][CH_CAP] ? capv(ci) : chr[ci][15:0]};
		else if (adr_i == ADR_T2_FAULT)
			rd = {28'h0, fault_en};
		else if (tsel && o == OFS_CTRL)
			rd = {20'h0, ctrl[t]};
		else if (tsel && o == OFS_MOD)
			rd = {16'h0, modv[t]};
		else if (tsel && o == OFS_CNT)
			rd = {16'h0, cnt[t]};
		else if (tsel && o == OFS_STAT)
			rd = {22'h0, stat[t]};
		else
			rd_ok = 1'b0;
	end

	function automatic logic [15:0] capv(input logic [3:0] k);
		logic [15:0] r;
		r = 16'h0;
		if (k < 4'd2)
			r = c0.cap_val[k*16 +: 16];
		else if (k < 4'd4)
			r = c1.cap_val[(k-2)*16 +: 16];
		else if (k < 4'd10)
			r = c2.cap_val[(k-4)*16 +: 16];
		return r;
	endfunction

	// Unmapped reads return zero; one wait-free ack per request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end
		else
		begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= rd_ok ? rd : 32'h0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			opt <= 32'h0;
		else if (wr && adr_i == ADR_OPTION)
			opt <= dat_i;
	end

	// Software sync is a one-cycle pulse per write of 1
	assign sw_sync = wr && adr_i == ADR_OPTION && dat_i[OPT_SW_SYNC];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= '{default: 12'h0};
			modv <= '{default: 16'hFFFF};
			chr  <= '{default: 18'h0};
			fault_en <= '0;
		end
		else if (wr)
		begin
			if (ci != 4'hF)
				chr[ci] <= dat_i[17:0];
			else if (adr_i == ADR_T2_FAULT)
				fault_en <= dat_i[FAULT_N-1:0];
			else if (tsel && o == OFS_CTRL)
				ctrl[t] <= (t == 2'd2) ? dat_i[11:0] : {7'h0, dat_i[4:0]};
			else if (tsel && o == OFS_MOD)
				modv[t] <= dat_i[15:0];
		end
	end

	// Status: set wins over write-one-to-clear
	for (genvar k = 0; k < 3; k++)
	begin : g_st
		logic [9:0] setv;
		logic [1:0] base;
		assign base = 2'(k);
		always_comb
		begin
			setv = 10'h0;
			setv[ST_OVF] = ovf[k];
			if (k == 0)
				setv[2:1] = c0.ch_evt & c0.cap_mode | c0.ch_evt & ~c0.cap_mode;
			else if (k == 1)
				setv[2:1] = c1.ch_evt;
			else
			begin
				setv[6:1] = c2.ch_evt;
				setv[ST_FAULT] = fault_any;
				setv[ST_SYNC] = |sync_trig;
			end
		end
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				stat[k] <= 10'h0;
			else if (wr && tsel && t == base && o == OFS_STAT)
				stat[k] <= (stat[k] & ~dat_i[9:0]) | setv;
			else
				stat[k] <= stat[k] | setv;
		end
		assign irq_o[k] = ctrl[k][CTRL_IE] && |stat[k];
	end

	// ----------------------------------------
	// Interconnect
	// ----------------------------------------
	assign c0.cap_in = {opt[OPT_RX_TAG] ? serial0_receive_i : t0_cap_pin_i[1],
		t0_cap_pin_i[0]};
	assign c1.cap_in = {opt[OPT_RTC_CAP] ? rtc_ovf_i : t1_cap_pin_i[1],
		opt[OPT_CMP_CAP] ? cmp_zero_i : t1_cap_pin_i[0]};
	assign c2.cap_in = {t2_cap_pin_i[5:4], t2_cap_f};

	for (genvar k = 0; k < FILT_CH; k++)
	begin : g_cf
		tpc_filter u_f (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.len_i (ctrl[2][CTRL_FILT_LO +: FILT_W]),
			.d_i   (t2_cap_pin_i[k]),
			.q_o   (t2_cap_f[k])
		);
	end

	assign fault_raw = {cmp_one_i, port_a_pin7_i, port_a_pin6_i, cmp_zero_i};
	for (genvar k = 0; k < FAULT_N; k++)
	begin : g_ff
		tpc_filter u_f (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.len_i (ctrl[2][CTRL_FILT_LO +: FILT_W]),
			.d_i   (fault_raw[k]),
			.q_o   (fault_f[k])
		);
	end
	assign fault_any = |(fault_f & fault_en);

	// Trigger 1 acts on the rising edge of timer zero channel 0
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			t0_ch0_d <= 1'b0;
		else
			t0_ch0_d <= c0.pwm_out[0];
	end
	assign sync_trig[0] = opt[OPT_CMP_TRIG] ? cmp_one_i : cmp_zero_i;
	assign sync_trig[1] = c0.pwm_out[0] && !t0_ch0_d;
	assign sync_trig[2] = sw_sync;

	// Faults force full timer outputs low; masking exists only there
	assign t0_pwm_o = c0.pwm_out;
	assign t1_pwm_o = c1.pwm_out;
	assign t2_pwm_o = fault_any ? '0 : c2.pwm_out;
	assign serial0_transmit_o = opt[OPT_TX_MOD] ?
		serial0_tx_raw_i & c0.pwm_out[0] : serial0_tx_raw_i;

	for (genvar k = 0; k < 2; k++)
	begin : g_bc
		assign c0.cap_mode[k] = chr[k][CH_CAP];
		assign c0.ch_val[k*16 +: 16] = chr[k][15:0];
		assign c1.cap_mode[k] = chr[k+2][CH_CAP];
		assign c1.ch_val[k*16 +: 16] = chr[k+2][15:0];
	end
	for (genvar k = 0; k < FULL_CH; k++)
	begin : g_fc
		assign c2.cap_mode[k] = chr[k+4][CH_CAP];
		assign c2.ch_val[k*16 +: 16] = chr[k+4][15:0];
	end

	// ----------------------------------------
	// Timers; no cross-timer time base is shared
	// ----------------------------------------
	tpc_timer #(.N(BASIC_CH)) u_t0 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.clock_source_select_i       (ctrl[0][CTRL_CLOCK_SOURCE_SELECT_LO +: 2]),
		.signed_i     (ctrl[0][CTRL_SIGNED]),
		.center_i     (ctrl[0][CTRL_CENTER]),
		.fixed_tick_i (fixed_tick_i),
		.ext_tick_i   (ext_tick_i[0]),
		.sync_i       (1'b0),
		.mod_i        (modv[0]),
		.cnt_o        (cnt[0]),
		.ovf_o        (ovf[0]),
		.ch           (c0.timer)
	);
	tpc_timer #(.N(BASIC_CH)) u_t1 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.clock_source_select_i       (ctrl[1][CTRL_CLOCK_SOURCE_SELECT_LO +: 2]),
		.signed_i     (ctrl[1][CTRL_SIGNED]),
		.center_i     (ctrl[1][CTRL_CENTER]),
		.fixed_tick_i (fixed_tick_i),
		.ext_tick_i   (ext_tick_i[1]),
		.sync_i       (1'b0),
		.mod_i        (modv[1]),
		.cnt_o        (cnt[1]),
		.ovf_o        (ovf[1]),
		.ch           (c1.timer)
	);
	tpc_timer #(.N(FULL_CH)) u_t2 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.clock_source_select_i       (ctrl[2][CTRL_CLOCK_SOURCE_SELECT_LO +: 2]),
		.signed_i     (ctrl[2][CTRL_SIGNED]),
		.center_i     (ctrl[2][CTRL_CENTER]),
		.fixed_tick_i (fixed_tick_i),
		.ext_tick_i   (ext_tick_i[2]),
		.sync_i       (|sync_trig),
		.mod_i        (modv[2]),
		.cnt_o        (cnt[2]),
		.ovf_o        (ovf[2]),
		.ch           (c2.timer)
	);
endmodule

// ---- core/tpc_pkg.sv ----
package tpc_pkg;
	// ----------------------------------------
	// Counter and clock source
	// ----------------------------------------
	localparam int CNT_W = 16;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_NONE = 2'h0;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_TIMER = 2'h1;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_FIXED = 2'h2;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT = 2'h3;
	localparam int BASIC_CH = 2;
	localparam int FULL_CH = 6;
	localparam int FILT_CH = 4;
	localparam int FAULT_N = 4;
	localparam int FILT_W = 4;

	// ----------------------------------------
	// Register map (byte addresses, word registers)
	// ----------------------------------------
	localparam logic [7:0] ADR_OPTION = 8'h00;
	localparam logic [7:0] ADR_T0_BASE = 8'h10;
	localparam logic [7:0] ADR_T1_BASE = 8'h30;
	localparam logic [7:0] ADR_T2_BASE = 8'h50;
	localparam logic [7:0] ADR_T2_CH45 = 8'h70;
	localparam logic [7:0] ADR_T2_FAULT = 8'h78;
	// Per-timer word offsets from the base
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MOD = 8'h04;
	localparam logic [7:0] OFS_CNT = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_C0 = 8'h10;
	localparam logic [7:0] OFS_C1 = 8'h14;
	localparam logic [7:0] OFS_C2 = 8'h18;
	localparam logic [7:0] OFS_C3 = 8'h1C;

	// Option register bits
	localparam int OPT_CMP_TRIG = 0;
	localparam int OPT_SW_SYNC = 1;
	localparam int OPT_CMP_CAP = 2;
	localparam int OPT_RTC_CAP = 3;
	localparam int OPT_RX_TAG = 4;
	localparam int OPT_TX_MOD = 5;
	// Control register fields
	localparam int CTRL_CLOCK_SOURCE_SELECT_LO = 0;
	localparam int CTRL_SIGNED = 2;
	localparam int CTRL_CENTER = 3;
	localparam int CTRL_IE = 4;
	localparam int CTRL_FILT_LO = 8;
	// Channel register: [15:0] value, [16] capture mode, [17] int enable (stored and read back, gates no request)
	localparam int CH_CAP = 16;
	localparam int CH_IE = 17;
	// Status bits: [0] overflow, [1+n] channel n, [8] fault, [9] sync seen
	localparam int ST_OVF = 0;
	localparam int ST_FAULT = 8;
	localparam int ST_SYNC = 9;
endpackage

// ---- core/tpc_ch_if.sv ----
`timescale 1ns/100ps
interface tpc_ch_if #(parameter int N = 2);
	logic [N-1:0]  cap_in;
	logic [N-1:0]  pwm_out;
	logic [N-1:0]  ch_evt;
	logic [N-1:0]  cap_mode;
	logic [N*16-1:0] ch_val;
	logic [N*16-1:0] cap_val;
	modport timer (input cap_in, cap_mode, ch_val, output pwm_out, ch_evt, cap_val);
	modport top (output cap_in, cap_mode, ch_val, input pwm_out, ch_evt, cap_val);
endinterface

// ---- core/tpc_timer.sv ----
`timescale 1ns/100ps
module tpc_timer
	import tpc_pkg::*;
#(
	parameter int N = 2
)(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [1:0]       clock_source_select_i,
	input  wire logic             signed_i,
	input  wire logic             center_i,
	input  wire logic             fixed_tick_i,
	input  wire logic             ext_tick_i,
	input  wire logic             sync_i,
	input  wire logic [CNT_W-1:0] mod_i,
	output logic      [CNT_W-1:0] cnt_o,
	output logic                  ovf_o,
	tpc_ch_if.timer               ch
);
	logic tick;
	logic down;
	logic wrap;
	logic [CNT_W-1:0] lo;

	// ----------------------------------------
	// Clock source select
	// ----------------------------------------
	always_comb
	begin
		case (clock_source_select_i)
			CLOCK_SOURCE_SELECT_TIMER: tick = 1'b1;
			CLOCK_SOURCE_SELECT_FIXED: tick = fixed_tick_i;
			CLOCK_SOURCE_SELECT_EXT:   tick = ext_tick_i;
			default:    tick = 1'b0;
		endcase
	end

	// Signed mode counts from minus the modulo; unsigned from zero
	assign lo = signed_i ? CNT_W'(-mod_i) : '0;
	assign wrap = center_i ? (down && cnt_o == lo) : (cnt_o == mod_i);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_o <= '0;
			down  <= 1'b0;
			ovf_o <= 1'b0;
		end
		else
		begin
			ovf_o <= tick && wrap;
			if (sync_i)
			begin
				cnt_o <= lo;
				down  <= 1'b0;
			end
			else if (tick)                          // Holds without a tick
			begin
				if (center_i)
				begin
					if (!down && cnt_o == mod_i)
						down <= 1'b1;
					else if (down && cnt_o == lo)
						down <= 1'b0;
					cnt_o <= (!down && cnt_o != mod_i) || (down && cnt_o == lo) ?
						cnt_o + 1'b1 : cnt_o - 1'b1;
				end
				else
					cnt_o <= wrap ? lo : cnt_o + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Channels: capture, compare, PWM
	// ----------------------------------------
	for (genvar i = 0; i < N; i++)
	begin : g_ch
		logic cap_d;
		logic [CNT_W-1:0] v;
		assign v = ch.ch_val[i*16 +: 16];
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				cap_d <= 1'b0;
				ch.ch_evt[i] <= 1'b0;
				ch.pwm_out[i] <= 1'b0;
				ch.cap_val[i*16 +: 16] <= '0;
			end
			else
			begin
				cap_d <= ch.cap_in[i];
				if (ch.cap_mode[i])
				begin
					ch.pwm_out[i] <= 1'b0;
					ch.ch_evt[i] <= tick && ch.cap_in[i] && !cap_d;
					if (tick && ch.cap_in[i] && !cap_d)
						ch.cap_val[i*16 +: 16] <= cnt_o;
				end
				else
				begin                               // compare sets match event
					ch.ch_evt[i] <= tick && cnt_o == v;
					if (signed_i)
						ch.pwm_out[i] <= $signed(cnt_o) < $signed(v);
					else
						ch.pwm_out[i] <= cnt_o < v;
				end
			end
		end
	end
endmodule

// ---- core/tpc_filter.sv ----
`timescale 1ns/100ps
module tpc_filter
	import tpc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [FILT_W-1:0] len_i,
	input  wire logic              d_i,
	output logic                   q_o
);
	logic [FILT_W-1:0] cnt;

	// Zero length passes the input straight through with one flop of delay
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			q_o <= 1'b0;
		end
		else if (d_i == q_o)
			cnt <= '0;
		else if (cnt >= len_i)
		begin
			cnt <= '0;
			q_o <= d_i;
		end
		else
			cnt <= cnt + 1'b1;
	end
endmodule

// ---- dv/tpc_side_model.sv ----
`timescale 1ns/100ps
module tpc_side_model (
	input  wire logic        clk_i,
	input  wire logic [2:0]  irq_i,
	output logic      [10:0] src_o,
	output int               irq_seen
);
	// ----------------------------------------
	// Sources: 0/1 comparators, 2/3 pins, 4 rtc, 5 rx, 6 tx, 7 fixed, 8-10 ext ticks
	// ----------------------------------------
	// Serial lines idle high, so a routed receive line already sits at one
	localparam logic [10:0] IDLE = 11'h060;
	logic [2:0] irq_q;
	initial
	begin
		src_o = IDLE;
		irq_q = 3'h0;
		irq_seen = 0;
	end
	// External ticks of each timer come on their own line
	task automatic pulse(input int b, input int n);
		@(posedge clk_i);
		src_o[b] <= ~IDLE[b];
		repeat (n) @(posedge clk_i);
		src_o[b] <= IDLE[b];
		repeat (4) @(posedge clk_i);
	endtask
	// One request line per timer; the source is found in status
	always @(posedge clk_i)
	begin
		irq_q <= irq_i;
		if (irq_i[0] && !irq_q[0])
			irq_seen <= irq_seen + 1;
	end
endmodule

// ---- dv/tpc_top_asserts.sv ----
`timescale 1ns/100ps
module tpc_top_asserts
	import tpc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        serial0_tx_raw_i,
	input wire logic        serial0_transmit_o,
	input wire logic [1:0]  t0_pwm_o,
	input wire logic [2:0]  irq_o
);
	// ----------------------------------------
	// Mirrors of written control bits
	// ----------------------------------------
	logic       opt_mod;
	logic [2:0] ie_m;
	logic [1:0] clks0;
	wire logic  wr_take = cyc_i && stb_i && !ack_o && we_i && (sel_i == 4'hF);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			opt_mod <= 1'b0;
			ie_m <= 3'h0;
			clks0 <= 2'h0;
		end
		else if (wr_take)
		begin
			if (adr_i == ADR_OPTION)
				opt_mod <= dat_i[OPT_TX_MOD];
			if (adr_i == ADR_T0_BASE)
				ie_m[0] <= dat_i[CTRL_IE];
			if (adr_i == ADR_T0_BASE)
				clks0 <= dat_i[1:0];
			if (adr_i == ADR_T1_BASE)
				ie_m[1] <= dat_i[CTRL_IE];
			if (adr_i == ADR_T2_BASE)
				ie_m[2] <= dat_i[CTRL_IE];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_NEXT: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("ack not in next cycle");
	AST_TX_RAW: assert property (!opt_mod |-> serial0_transmit_o == serial0_tx_raw_i)
		else $error("transmit not raw");
	AST_TX_MOD: assert property (opt_mod |->
		serial0_transmit_o == (serial0_tx_raw_i & t0_pwm_o[0]))
		else $error("transmit not modulated");
	AST_IRQ_GATE: assert property ((irq_o & ~ie_m) == 3'h0)
		else $error("request without enable");
	AST_SYNC_RD: assert property ((ack_o && !$past(we_i) && $past(adr_i) == ADR_OPTION)
		|-> !dat_o[OPT_SW_SYNC])
		else $error("software sync bit reads one");
	// Idle bus for three cycles so a fresh compare value has settled
	AST_CLK_OFF: assert property ((clks0 == CLOCK_SOURCE_SELECT_NONE && !cyc_i)[*3]
		|=> $stable(t0_pwm_o[0]))
		else $error("output moved with no clock");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=>
		(ack_o == 1'b0 && irq_o == 3'h0 && t0_pwm_o == 2'h0))
		else $error("outputs active after reset");
	COV_TX: cover property (opt_mod && t0_pwm_o[0]);
	COV_IRQ: cover property (irq_o[0]);
	COV_RD: cover property (ack_o && !$past(we_i));
endmodule
bind tpc_top tpc_top_asserts u_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .dat_o, .ack_o, .serial0_tx_raw_i, .serial0_transmit_o, .t0_pwm_o, .irq_o);

// ---- dv/test_tpc_top.sv ----
`timescale 1ns/100ps
module test_tpc_top;
	import tpc_pkg::*;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, serial0_transmit_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rdat, a;
	logic [10:0] src;
	logic [1:0]  t0_pwm_o, t1_pwm_o;
	logic [5:0]  t2_pwm_o;
	logic [2:0]  irq_o;
	int          err_count, compares;
	logic [7:0]  cbase[3] = '{ADR_T1_BASE, ADR_T1_BASE, ADR_T0_BASE};
	logic [7:0]  cofs[3] = '{OFS_C0, OFS_C1, OFS_C1};
	int          cbit[3] = '{OPT_CMP_CAP, OPT_RTC_CAP, OPT_RX_TAG};
	int          csrc[3] = '{0, 4, 5};
	int          cst[3] = '{1, 2, 2};
	int          sopt[5] = '{0, 1, 1, 2, 0};
	int          ssrc[5] = '{0, 0, 1, -1, -1};
	logic        sexp[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	int          fsrc[4] = '{0, 2, 3, 1};
	tpc_side_model side (.clk_i(clk_i), .irq_i(irq_o), .src_o(src), .irq_seen());
	tpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fixed_tick_i(src[7]), .ext_tick_i(src[10:8]), .cmp_zero_i(src[0]),
		.cmp_one_i(src[1]), .port_a_pin6_i(src[2]), .port_a_pin7_i(src[3]),
		.rtc_ovf_i(src[4]), .serial0_receive_i(src[5]), .serial0_tx_raw_i(src[6]),
		.serial0_transmit_o(serial0_transmit_o), .t0_cap_pin_i(2'h0), .t1_cap_pin_i(2'h0),
		.t2_cap_pin_i(6'h00), .t0_pwm_o(t0_pwm_o), .t1_pwm_o(t1_pwm_o),
		.t2_pwm_o(t2_pwm_o), .irq_o(irq_o));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		sel_i <= 4'hF;
		dat_i <= d;
		forever
		begin
			@(posedge clk_i);
			if (ack_o === 1'b1)
				break;
		end
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad);
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tick_chk(input logic [7:0] b, input logic [1:0] c, input int s,
		input int n, input logic [31:0] e);
		wr(b + OFS_CTRL, {30'h0, c});
		rd(b + OFS_CNT);
		a = rdat;
		side.pulse(s, n);
		rd(b + OFS_CNT);
		check_word(rdat - a, e);
	endtask
	task print_verdict;
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		print_verdict;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		err_count = 0;
		compares = 0;
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADR_OPTION);
		check_word(rdat, 32'h0);
		rd(ADR_T0_BASE + OFS_MOD);
		check_word(rdat, 32'h0000FFFF);
		rd(ADR_T0_BASE + OFS_C2);
		check_word(rdat, 32'h0);
		rd(8'hF0);
		check_word(rdat, 32'h0);
		wr(ADR_T2_BASE + OFS_C2, 32'h1234);
		rd(ADR_T2_BASE + OFS_C2);
		check_word(rdat & 32'hFFFF, 32'h1234);
		wr(ADR_T0_BASE, 32'hF00);
		rd(ADR_T0_BASE);
		check_word(rdat, 32'h0);
		wr(ADR_T2_BASE, 32'h300);
		rd(ADR_T2_BASE);
		check_word(rdat, 32'h300);
		wr(ADR_OPTION, 32'h3F);
		rd(ADR_OPTION);
		check_word(rdat, 32'h3D);
		wr(ADR_OPTION, 32'h0);
		tick_chk(ADR_T0_BASE, CLOCK_SOURCE_SELECT_FIXED, 7, 5, 32'h5);
		tick_chk(ADR_T0_BASE, CLOCK_SOURCE_SELECT_NONE, 7, 5, 32'h0);
		tick_chk(ADR_T0_BASE, CLOCK_SOURCE_SELECT_NONE, 8, 5, 32'h0);
		tick_chk(ADR_T1_BASE, CLOCK_SOURCE_SELECT_EXT, 9, 4, 32'h4);
		tick_chk(ADR_T0_BASE, CLOCK_SOURCE_SELECT_EXT, 9, 4, 32'h0);
		tick_chk(ADR_T2_BASE, CLOCK_SOURCE_SELECT_EXT, 10, 3, 32'h3);
		wr(ADR_T0_BASE, {30'h0, CLOCK_SOURCE_SELECT_TIMER});
		rd(ADR_T0_BASE + OFS_CNT);
		a = rdat;
		rd(ADR_T0_BASE + OFS_CNT);
		check_bit(rdat[15:0] !== a[15:0], 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			wr(cbase[i], {30'h0, CLOCK_SOURCE_SELECT_TIMER});
			wr(cbase[i] + cofs[i], 32'h10000);
			for (int r = 0; r < 2; r++)
			begin
				wr(ADR_OPTION, 32'(r) << cbit[i]);
				wr(cbase[i] + OFS_STAT, 32'h3FF);
				side.pulse(csrc[i], 2);
				rd(cbase[i] + OFS_STAT);
				check_bit(rdat[cst[i]], r[0]);
			end
		end
		wr(ADR_T2_BASE, {30'h0, CLOCK_SOURCE_SELECT_TIMER});
		for (int i = 0; i < 5; i++)
		begin
			wr(ADR_T2_BASE + OFS_STAT, 32'h3FF);
			wr(ADR_OPTION, 32'(sopt[i]));
			if (ssrc[i] >= 0)
				side.pulse(ssrc[i], 2);
			rd(ADR_T2_BASE + OFS_STAT);
			check_bit(rdat[ST_SYNC], sexp[i]);
		end
		wr(ADR_T2_BASE + OFS_STAT, 32'h3FF);
		wr(ADR_T0_BASE + OFS_C0, 32'hFFFF);
		wr(ADR_OPTION, 32'h1 << OPT_TX_MOD);
		rd(ADR_T2_BASE + OFS_STAT);
		check_bit(rdat[ST_SYNC], 1'b1);
		@(negedge clk_i);
		check_bit(serial0_transmit_o, 1'b1);
		wr(ADR_T0_BASE + OFS_C0, 32'h0);
		repeat (3) @(negedge clk_i);
		check_bit(serial0_transmit_o, 1'b0);
		wr(ADR_OPTION, 32'h0);
		@(negedge clk_i);
		check_bit(serial0_transmit_o, 1'b1);
		wr(ADR_T1_BASE + OFS_C0, 32'hFFFF);
		wr(ADR_T2_BASE + OFS_C0, 32'hFFFF);
		repeat (3) @(negedge clk_i);
		check_word({30'h0, t1_pwm_o[0], t2_pwm_o[0]}, 32'h3);
		// Each fault enable bit alone, against its own source line
		for (int i = 0; i < 4; i++)
		begin
			wr(ADR_T2_FAULT, 32'h1 << i);
			wr(ADR_T2_BASE + OFS_STAT, 32'h3FF);
			fork
				side.pulse(fsrc[i], 6);
				begin
					repeat (4) @(negedge clk_i);
					check_bit(t2_pwm_o[0], 1'b0);
				end
			join
			rd(ADR_T2_BASE + OFS_STAT);
			check_bit(rdat[ST_FAULT], 1'b1);
		end
		rd(ADR_T2_FAULT);
		check_word(rdat, 32'h8);
		// Second reset in mid-run, then an overflow raises the request
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(ADR_T0_BASE + OFS_MOD, 32'h3);
		wr(ADR_T0_BASE, 32'h10 | CLOCK_SOURCE_SELECT_TIMER);
		repeat (20) @(negedge clk_i);
		check_bit(irq_o[0], 1'b1);
		check_word({30'h0, irq_o[2:1]}, 32'h0);
		rd(ADR_T0_BASE + OFS_STAT);
		check_bit(rdat[ST_OVF], 1'b1);
		wr(ADR_T0_BASE, 32'h10);
		wr(ADR_T0_BASE + OFS_STAT, 32'h3FF);
		repeat (3) @(negedge clk_i);
		check_bit(irq_o[0], 1'b0);
		check_word(32'(side.irq_seen), 32'h1);
		print_verdict;
	end
endmodule
